// >>> pkg/ftsp_pkg.sv
// Constants and types shared by the flow-through synchronous SRAM port
package ftsp_pkg;

    // ==========================================================
    // Organisation
    // ==========================================================
    // Set to 1'b0 for the 256K x 18 organisation
    localparam bit FTSP_WIDE = 1'b1;
    localparam int LANE_BITS = 9;
    localparam int WIDE_LANES = 4;
    localparam int NARROW_LANES = 2;
    localparam int WIDE_WORDS = 131072;
    localparam int NARROW_WORDS = 262144;
    localparam int LANES = FTSP_WIDE ? WIDE_LANES : NARROW_LANES;
    localparam int DATA_W = LANES * LANE_BITS;
    localparam int WORDS = FTSP_WIDE ? WIDE_WORDS : NARROW_WORDS;
    localparam int ADDR_W = $clog2(WORDS);
    localparam int BURST_W = 2;
    localparam int UPPER_W = ADDR_W - BURST_W;

    // ==========================================================
    // Buffering
    // ==========================================================
    localparam int WQ_DEPTH = 32;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [BURST_W-1:0] BURST_CNT_RST = 2'h0;
    localparam logic [LANES-1:0] LANE_MASK_RST = '0;

    // ==========================================================
    // Operation held in the command registers
    // ==========================================================
    typedef enum logic [1:0] {
        OP_DESELECT = 2'b00,
        OP_READ = 2'b01,
        OP_WRITE = 2'b10
    } ftsp_op_type;

    // One queued array write
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [LANES-1:0] mask;
    } ftsp_wentry_type;

endpackage

// >>> rtl/ftsp_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module ftsp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Filling side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Draining side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);

    // ==========================================================
    // Storage and pointers
    // ==========================================================
    localparam int PTR_W = $clog2(DEPTH);
    logic [WIDTH-1:0] store [0:DEPTH-1];
    // Extra bit tells full from empty when the indices meet
    logic [PTR_W:0] wrPtr_q;
    logic [PTR_W:0] rdPtr_q;
    logic isEmpty;
    logic isFull;
    logic doPush;
    logic doPop;

    assign isEmpty = (wrPtr_q == rdPtr_q);
    assign isFull = (wrPtr_q[PTR_W] != rdPtr_q[PTR_W]) &&
                    (wrPtr_q[PTR_W-1:0] == rdPtr_q[PTR_W-1:0]);
    assign inReady = !isFull;
    assign outValid = !isEmpty;
    assign outData = store[rdPtr_q[PTR_W-1:0]];
    assign doPush = inValid && !isFull;
    assign doPop = outReady && !isEmpty;

    // ==========================================================
    // Pointer update
    // ==========================================================
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end else begin
            if (doPush) begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (doPop) begin
                rdPtr_q <= rdPtr_q + 1'b1;
            end
        end
    end

    // ==========================================================
    // Storage write
    // ==========================================================
    always_ff @(posedge clk_sys) begin
        if (doPush) begin
            store[wrPtr_q[PTR_W-1:0]] <= inData;
        end
    end

endmodule // ftsp_fifo

// >>> rtl/ftsp_port.sv
// Flow-through synchronous static RAM with burst counter and byte writes
`timescale 1ns/100ps

// Notes on behaviour
// - Address, write data and controls, except drive enable and order, registered on edge.
// - Writes start on the clock edge and are timed internally.
// - Read data flows from the array to the bus with no output register.
// - Wide organisation: 131072 words of 36 bits in four byte lanes.
// - Narrow organisation: 262144 words of 18 bits in two byte lanes.
// - A two-bit burst counter generates the low address bits.
// - Load step low loads a new address; high uses the advanced burst address.
// - Clock gate high: no inputs registered, internal state held.
// - Order select low linear, high interleaved; never registered.
// - Burst start bits set the burst origin when an address loads; the counter itself clears to zero.
// - Primary chip select is active low and must be asserted.
// - Depth selects high and low must also match before selection.
// - Only lanes with their byte select asserted are written; reads ignore selects.
// - Unselected lanes of the addressed word stay unchanged on writes.
// - Each lane carries its own byte; the data bus is bidirectional.
// - Read-write and write-read on consecutive cycles with no idle cycle.
// - With load step high, selects, strobe, address and start bits are ignored; byte selects hold from the load.
// - Byte selects for a write sampled only when the write address loads.
// - Burst writes advance the address even with no byte selected.
module ftsp_port
    import ftsp_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Clock gate, active low
    input wire logic edge_gate_n,
    // Address
    input wire logic [UPPER_W-1:0] address_in,
    input wire logic [BURST_W-1:0] burst_start_bits,
    // Controls
    input wire logic burst_load_step,
    input wire logic burst_order_select,
    input wire logic chip_select_primary_n,
    input wire logic depth_select_high,
    input wire logic depth_select_low_n,
    input wire logic write_strobe_n,
    input wire logic [LANES-1:0] byte_write_select_n,
    input wire logic output_drive_on_n,
    // Data lanes, split two-way pin
    input wire logic [DATA_W-1:0] dataLaneIn,
    output logic [DATA_W-1:0] dataLaneOut,
    output logic dataLaneOeN,
    // Write queue back-pressure
    output logic writeQueueReady
);

    // ==========================================================
    // Burst address arithmetic
    // ==========================================================
    function automatic logic [BURST_W-1:0] burstLow(
        input logic [BURST_W-1:0] start,
        input logic [BURST_W-1:0] count,
        input logic interleave
    );
        logic [BURST_W-1:0] res;
        res = '0;
        if (interleave) begin
            res = start ^ count;
        end else begin
            res = start + count;
        end
        return res;
    endfunction

    // Merge new lanes over an old word under a lane mask
    function automatic logic [DATA_W-1:0] laneMerge(
        input logic [DATA_W-1:0] oldWord,
        input logic [DATA_W-1:0] newWord,
        input logic [LANES-1:0] mask
    );
        logic [DATA_W-1:0] res;
        res = oldWord;
        for (int i = 0; i < LANES; i++) begin
            if (mask[i]) begin
                res[i*LANE_BITS +: LANE_BITS] = newWord[i*LANE_BITS +: LANE_BITS];
            end
        end
        return res;
    endfunction

    // ==========================================================
    // Declarations
    // ==========================================================
    // Array sized for the chosen organisation
    logic [DATA_W-1:0] memArray [0:WORDS-1];

    ftsp_op_type op_q;
    ftsp_op_type op_d;
    logic [UPPER_W-1:0] upper_q;
    logic [UPPER_W-1:0] upper_d;
    logic [BURST_W-1:0] start_q;
    logic [BURST_W-1:0] start_d;
    logic [BURST_W-1:0] burstCnt_q;
    logic [BURST_W-1:0] burstCnt_d;
    logic [LANES-1:0] laneMask_q;
    logic [LANES-1:0] laneMask_d;
    logic wrPend_q;
    logic wrPend_d;
    logic [ADDR_W-1:0] wrAddr_q;
    logic [ADDR_W-1:0] wrAddr_d;
    logic [LANES-1:0] wrMask_q;
    logic [LANES-1:0] wrMask_d;

    logic edgeLive;
    logic selected;
    logic [ADDR_W-1:0] curAddr;
    logic [DATA_W-1:0] arrayWord;
    logic [DATA_W-1:0] readWord;

    ftsp_wentry_type pushEntry;
    ftsp_wentry_type headEntry;
    logic pushValid;
    logic pushReady;
    logic headValid;
    logic headTake;

    // ==========================================================
    // Qualifiers
    // ==========================================================
    // A high gate behaves as if the edge never arrived
    assign edgeLive = !edge_gate_n;

    // All three selects must agree before the port is selected
    assign selected = !chip_select_primary_n &&
                      depth_select_high &&
                      !depth_select_low_n;

    // Order select feeds the counter directly, never through a flop
    assign curAddr = {upper_q, burstLow(start_q, burstCnt_q, burst_order_select)};

    // ==========================================================
    // Next command state
    // ==========================================================
    always_comb begin
        op_d = op_q;
        upper_d = upper_q;
        start_d = start_q;
        burstCnt_d = burstCnt_q;
        laneMask_d = laneMask_q;
        if (!burst_load_step) begin
            // Load cycle: a new address or a deselect
            if (selected) begin
                upper_d = address_in;
                start_d = burst_start_bits;
                burstCnt_d = BURST_CNT_RST;
                if (!write_strobe_n) begin
                    op_d = OP_WRITE;
                    laneMask_d = ~byte_write_select_n;
                end else begin
                    op_d = OP_READ;
                end
            end else begin
                // One deselect cycle is enough to stop driving
                op_d = OP_DESELECT;
            end
        end else begin
            // Advance cycle: selects, strobe and address are ignored
            case (op_q)
                OP_READ,
                OP_WRITE: begin
                    burstCnt_d = burstCnt_q + 1'b1;
                end
                OP_DESELECT: begin
                    burstCnt_d = burstCnt_q;
                end
                default: begin
                    op_d = OP_DESELECT;
                end
            endcase
        end
    end

    // Data for a write address arrives one live edge later
    always_comb begin
        wrPend_d = (op_d == OP_WRITE);
        wrAddr_d = wrAddr_q;
        wrMask_d = wrMask_q;
        if (op_d == OP_WRITE) begin
            if (!burst_load_step) begin
                wrAddr_d = {address_in, burst_start_bits};
            end else begin
                wrAddr_d = {upper_q, burstLow(start_q, burstCnt_d, burst_order_select)};
            end
            wrMask_d = laneMask_d;
        end
    end

    // ==========================================================
    // Command registers
    // ==========================================================
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            op_q <= OP_DESELECT;
            upper_q <= '0;
            start_q <= BURST_CNT_RST;
            burstCnt_q <= BURST_CNT_RST;
            laneMask_q <= LANE_MASK_RST;
        end else if (edgeLive) begin
            op_q <= op_d;
            upper_q <= upper_d;
            start_q <= start_d;
            burstCnt_q <= burstCnt_d;
            laneMask_q <= laneMask_d;
        end
    end

    // ==========================================================
    // Pending write registers
    // ==========================================================
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wrPend_q <= 1'b0;
            wrAddr_q <= '0;
            wrMask_q <= LANE_MASK_RST;
        end else if (edgeLive) begin
            wrPend_q <= wrPend_d;
            wrAddr_q <= wrAddr_d;
            wrMask_q <= wrMask_d;
        end
    end

    // ==========================================================
    // Write queue
    // ==========================================================
    // Write data is taken at the live edge after its address
    assign pushEntry.addr = wrAddr_q;
    assign pushEntry.data = dataLaneIn;
    assign pushEntry.mask = wrMask_q;
    assign pushValid = edgeLive && wrPend_q;
    assign writeQueueReady = pushReady;

    // Draining stops while the gate holds the port frozen
    assign headTake = edgeLive;

    ftsp_fifo #(
        .WIDTH($bits(ftsp_wentry_type)),
        .DEPTH(WQ_DEPTH)
    ) u_write_queue (
        .clk_sys(clk_sys),
        .srst(srst),
        .inValid(pushValid),
        .inReady(pushReady),
        .inData(pushEntry),
        .outValid(headValid),
        .outReady(headTake),
        .outData(headEntry)
    );

    // ==========================================================
    // Array write
    // ==========================================================
    // Self-timed: the controller never shapes a write pulse
    always_ff @(posedge clk_sys) begin
        if (headValid && headTake) begin
            for (int i = 0; i < LANES; i++) begin
                if (headEntry.mask[i]) begin
                    memArray[headEntry.addr][i*LANE_BITS +: LANE_BITS] <=
                        headEntry.data[i*LANE_BITS +: LANE_BITS];
                end
            end
        end
    end

    // ==========================================================
    // Read path
    // ==========================================================
    // No output stage: the word flows straight out of the array
    assign arrayWord = memArray[curAddr];

    // A write still queued for this address must be seen at once,
    // so back-to-back write then read needs no idle cycle
    always_comb begin
        readWord = arrayWord;
        if (headValid && (headEntry.addr == curAddr)) begin
            readWord = laneMerge(arrayWord, headEntry.data, headEntry.mask);
        end
    end

    assign dataLaneOut = readWord;

    // Drive only for a read and only while the enable is low;
    // the enable is not sampled, so it acts without the clock
    assign dataLaneOeN = !((op_q == OP_READ) && !output_drive_on_n);

endmodule // ftsp_port

// >>> verification/ftsp_port_chk.sv
// Pin-level assertions for the flow-through SRAM port
`timescale 1ns/100ps
module ftsp_port_chk
    import ftsp_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Controls
    input wire logic edge_gate_n,
    input wire logic burst_load_step,
    input wire logic chip_select_primary_n,
    input wire logic depth_select_high,
    input wire logic depth_select_low_n,
    input wire logic write_strobe_n,
    input wire logic output_drive_on_n,
    // Data lanes
    input wire logic [DATA_W-1:0] dataLaneOut,
    input wire logic dataLaneOeN,
    input wire logic writeQueueReady
);
    logic ld;
    logic sel;
    assign ld = !edge_gate_n && !burst_load_step;
    assign sel = !chip_select_primary_n && depth_select_high && !depth_select_low_n;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    sequence s_rd; ld && sel && write_strobe_n; endsequence
    sequence s_wr; ld && sel && !write_strobe_n; endsequence
    // ==========================================================
    // Properties
    property p_rd; s_rd |=> dataLaneOeN == output_drive_on_n; endproperty
    a_rd: assert property (p_rd) else $error("read drive wrong");
    property p_wr; s_wr |=> dataLaneOeN; endproperty
    a_wr: assert property (p_wr) else $error("write drove lanes");
    property p_cs; ld && chip_select_primary_n |=> dataLaneOeN; endproperty
    a_cs: assert property (p_cs) else $error("unselected but driving");
    property p_depth; ld && (!depth_select_high || depth_select_low_n) |=> dataLaneOeN; endproperty
    a_depth: assert property (p_depth) else $error("depth select ignored");
    // Drive enable is asynchronous, so hold is only claimed while it stays put
    property p_gate;
        edge_gate_n ##1 $stable(output_drive_on_n) |-> $stable(dataLaneOeN) && (dataLaneOeN || $stable(dataLaneOut));
    endproperty
    a_gate: assert property (p_gate) else $error("gated edge changed state");
    property p_adv; !edge_gate_n && burst_load_step && !dataLaneOeN |=> dataLaneOeN == output_drive_on_n; endproperty
    a_adv: assert property (p_adv) else $error("burst read not continued");
    property p_oe; output_drive_on_n |-> dataLaneOeN; endproperty
    a_oe: assert property (p_oe) else $error("driving while disabled");
    property p_w2r; s_wr ##1 s_rd |-> dataLaneOeN ##1 dataLaneOeN == output_drive_on_n; endproperty
    a_w2r: assert property (p_w2r) else $error("write then read turnaround wrong");
    property p_wq; s_wr |=> writeQueueReady [*2]; endproperty
    a_wq: assert property (p_wq) else $error("write queue stalled");
    c_rd: cover property (s_rd ##1 !dataLaneOeN);
    c_gate: cover property (edge_gate_n && !dataLaneOeN);
    c_w2r: cover property (s_wr ##1 s_rd);
    c_r2w: cover property (s_rd ##1 s_wr);
endmodule // ftsp_port_chk

bind ftsp_port ftsp_port_chk u_chk (
    .clk_sys(clk_sys), .srst(srst), .edge_gate_n(edge_gate_n), .burst_load_step(burst_load_step),
    .chip_select_primary_n(chip_select_primary_n), .depth_select_high(depth_select_high),
    .depth_select_low_n(depth_select_low_n), .write_strobe_n(write_strobe_n),
    .output_drive_on_n(output_drive_on_n), .dataLaneOut(dataLaneOut), .dataLaneOeN(dataLaneOeN),
    .writeQueueReady(writeQueueReady)
);

// >>> verification/ftsp_ctrl_model.sv
// Controller-side lane model: drives write data and resolves the shared lanes
`timescale 1ns/100ps
module ftsp_ctrl_model
    import ftsp_pkg::*;
(
    // Clock
    input wire logic clk_sys,
    // Write data from the bench
    input wire logic wrDrive,
    input wire logic [DATA_W-1:0] wrData,
    // Device side of the lanes
    input wire logic [DATA_W-1:0] dataLaneOut,
    input wire logic dataLaneOeN,
    output logic [DATA_W-1:0] dataLaneIn
);
    logic [DATA_W-1:0] lastLane_q = '0;
    // Undriven lanes show the inverse, so a stale value never passes for data
    always_comb begin
        if (!dataLaneOeN) begin
            dataLaneIn = dataLaneOut;
        end else if (wrDrive) begin
            dataLaneIn = wrData;
        end else begin
            dataLaneIn = ~lastLane_q;
        end
    end
    // Plain always: the declaration above also gives this variable its start value
    always @(posedge clk_sys) begin
        lastLane_q <= dataLaneIn;
    end
endmodule // ftsp_ctrl_model

// >>> verification/ftsp_port_tb.sv
// Self-checking bench for the flow-through SRAM port
`timescale 1ns/100ps
module ftsp_port_tb;
    import ftsp_pkg::*;
    logic clk_sys, srst, edge_gate_n, burst_load_step, burst_order_select, write_strobe_n;
    logic chip_select_primary_n, depth_select_high, depth_select_low_n, output_drive_on_n;
    logic [UPPER_W-1:0] address_in;
    logic [BURST_W-1:0] burst_start_bits;
    logic [LANES-1:0] byte_write_select_n, curM, pendM;
    logic [DATA_W-1:0] dataLaneIn, dataLaneOut, wrData, prevData;
    logic dataLaneOeN, writeQueueReady, wrDrive, pendV, prevRd;
    logic [DATA_W-1:0] mem [16];
    logic [DATA_W:0] q [$];
    int n_mismatch = 0;
    int checked = 0;
    int op, cnt, upA, stA, pendA;

    ftsp_port dut (
        .clk_sys(clk_sys), .srst(srst), .edge_gate_n(edge_gate_n), .address_in(address_in),
        .burst_start_bits(burst_start_bits), .burst_load_step(burst_load_step),
        .burst_order_select(burst_order_select), .chip_select_primary_n(chip_select_primary_n),
        .depth_select_high(depth_select_high), .depth_select_low_n(depth_select_low_n),
        .write_strobe_n(write_strobe_n), .byte_write_select_n(byte_write_select_n),
        .output_drive_on_n(output_drive_on_n), .dataLaneIn(dataLaneIn), .dataLaneOut(dataLaneOut),
        .dataLaneOeN(dataLaneOeN), .writeQueueReady(writeQueueReady)
    );
    ftsp_ctrl_model partner (
        .clk_sys(clk_sys), .wrDrive(wrDrive), .wrData(wrData), .dataLaneOut(dataLaneOut),
        .dataLaneOeN(dataLaneOeN), .dataLaneIn(dataLaneIn)
    );

    initial begin
        clk_sys = 0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic end_of_test();
        if (n_mismatch == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // Monitor: each entry describes the lanes seen at the next edge
    always @(posedge clk_sys) begin
        if (srst === 1'b0 && q.size() > 0) begin
            checked++;
            if ({dataLaneOeN, dataLaneOut} !== q[0] && !(q[0][DATA_W] && dataLaneOeN === 1'b1)) begin
                $display("CHECK FAILED lanes exp %h got %h", q[0], {dataLaneOeN, dataLaneOut});
                n_mismatch++;
            end
            // Drain runs every live edge, so the queue never fills in normal use
            if (writeQueueReady !== 1'b1) begin
                $display("CHECK FAILED writeQueueReady exp 1 got %b", writeQueueReady);
                n_mismatch++;
            end
            q.delete(0);
        end
    end

    // ==========================================================
    // One bus cycle; advance cycles drive junk on every ignored control
    task automatic cyc(bit ld, bit sl, bit wr, int up, int st, logic [LANES-1:0] m);
        int k;
        int a;
        @(negedge clk_sys);
        edge_gate_n = 0;
        output_drive_on_n = ($urandom % 4 == 0);
        q.push_back({!(prevRd && !output_drive_on_n), prevData});
        wrDrive = pendV;
        wrData = DATA_W'({$urandom, $urandom});
        for (int i = 0; i < LANES; i++) begin
            if (pendV && pendM[i]) mem[pendA][i*LANE_BITS +: LANE_BITS] = wrData[i*LANE_BITS +: LANE_BITS];
        end
        if (ld) begin
            {op, upA, stA, cnt, curM} = {sl ? (wr ? 2 : 1) : 0, up, st, 0, ~m};
        end else if (op != 0) begin
            cnt++;
        end
        a = upA * 4 + ((burst_order_select ? stA ^ cnt : stA + cnt) & 3);
        {pendV, pendA, pendM, prevRd} = {op == 2, a, curM, op == 1};
        prevData = mem[a];
        k = ld ? (sl ? 3 : $urandom % 3) : $urandom;
        burst_load_step = !ld;
        write_strobe_n = ld ? !wr : k[3];
        chip_select_primary_n = ld ? k == 0 : k[0];
        depth_select_high = ld ? k != 1 : k[1];
        depth_select_low_n = ld ? k == 2 : k[2];
        address_in = UPPER_W'(ld ? up : $urandom);
        burst_start_bits = BURST_W'(ld ? st : $urandom);
        byte_write_select_n = ld ? m : LANES'($urandom);
    endtask

    // Gated edge: load step, chip select and address scrambled, state must hold
    task automatic gate();
        @(negedge clk_sys);
        edge_gate_n = 1;
        q.push_back({!(prevRd && !output_drive_on_n), prevData});
        burst_load_step = 1'($urandom);
        chip_select_primary_n = 1'($urandom);
        address_in = UPPER_W'($urandom);
    endtask

    task automatic do_reset(bit o);
        @(negedge clk_sys);
        {srst, burst_load_step, chip_select_primary_n, wrDrive} = 4'hA;
        burst_order_select = o;
        repeat (3) @(negedge clk_sys);
        {srst, op, pendV, prevRd} = '0;
        q.push_back({1'b1, prevData});
    endtask

    initial begin
        repeat (3000) @(posedge clk_sys);
        n_mismatch++;
        end_of_test();
    end

    initial begin
        {srst, edge_gate_n, burst_load_step, burst_order_select, write_strobe_n} = 5'h18;
        {chip_select_primary_n, depth_select_high, depth_select_low_n, output_drive_on_n} = 4'hC;
        {address_in, burst_start_bits, byte_write_select_n} = '0;
        {wrDrive, wrData, pendV, prevRd} = '0;
        void'($urandom(68760));
        for (int o = 0; o < 2; o++) begin
            do_reset(o == 1);
            for (int i = 0; i < 16; i++) cyc(i % 4 == 0, 1, 1, i / 4, 0, '0);
            repeat (300) begin
                if ($urandom % 8 == 0) gate();
                cyc($urandom % 2, $urandom % 4 != 0, 1'($urandom), $urandom % 4, $urandom % 4, LANES'($urandom));
            end
            cyc(1, 0, 0, 0, 0, '1);
            cyc(1, 0, 0, 0, 0, '1);
        end
        @(posedge clk_sys);
        #1;
        end_of_test();
    end
endmodule // ftsp_port_tb
